// >>> rtl/ccdt_timing_gen.sv
// Summary of operation
// - Full 15 fps: 1456 lines, 1650 clocks, 36MHz.
// - Full 12.5 fps: 1450 lines, 1600 clocks, 29MHz.
// - Full 22.5 fps: 1001 lines, 1600 clocks, 36MHz.
// - Window 30 fps: 750x1598 plus 2700 line.
// - Window 25 fps: 744x1556 plus 2336 line.
// - Full 15 fps sweep ends line 60, 144.
// - Full 12.5 fps sweep ends line 52, 120.
// - Window 30 fps sweep ends line 8, 144.
// - Window 25 fps sweep ends line 6, 120.
// - Drain rises with first storage gate fall.
// - Drain falls with following hold gate rise.
// - Positions count from line sync, per rate.
// - Normal transfer positions shared by both rates.
// - Smear test: no readout, drain in each transfer line blanking.
// - No drain pulse during frame shift.
`timescale 1ns/10ps

module ccdt_timing_gen
   import ccdt_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic [2:0] mode_sel,
   input wire logic smear_test,
   output logic line_sync_pulse_n_ff,
   output logic frame_sync_pulse_n_ff,
   output logic vertical_storage_gate_ff,
   output logic vertical_hold_gate_ff,
   output logic substrate_drain_ff,
   output logic readout_pulse_ff,
   output logic sweep_active_ff,
   output logic frame_shift_ff,
   output ccdt_pix_t pix_cnt_ff,
   output ccdt_line_t line_cnt_ff
);

   ccdt_state_e state_ff;
   ccdt_state_e nxt_state;
   ccdt_mode_e mode_ff;
   ccdt_mode_e nxt_mode;
   ccdt_pix_t nxt_pix;
   ccdt_line_t nxt_line;
   logic nxt_sweep;
   logic nxt_shift;

   ccdt_cnt_if u_cif ();

   // Mode decode: an unknown code falls back to full-frame 15 fps.
   wire logic mode_ok = (mode_sel < 3'h5);
   wire ccdt_mode_e req_mode = mode_ok ? ccdt_mode_e'(mode_sel) : CCDT_FF15;
   wire logic req_has_sweep = (CCDT_SWEEP_LINES[req_mode] != 11'h000);
   wire ccdt_state_e start_state = req_has_sweep ? CCDT_ST_SWEEP
                                                 : CCDT_ST_SHIFT;

   // Per-mode selection from the tables for the latched mode.
   wire ccdt_pix_t line_len = CCDT_LINE_LEN[mode_ff];
   wire ccdt_pix_t adj_len = CCDT_ADJ_LEN[mode_ff];
   wire ccdt_line_t frame_lines = CCDT_FRAME_LINES[mode_ff];
   wire ccdt_line_t sweep_last = CCDT_SWEEP_LINES[mode_ff] - 11'h001;
   wire ccdt_pix_t sweep_end = CCDT_SWEEP_END[mode_ff];
   wire logic rate29 = CCDT_RATE29[mode_ff];

   // The adjustment line follows the normal lines of a window frame.
   wire logic has_adj = (adj_len != 12'h000);
   wire logic adj_line = has_adj && (line_cnt_ff == frame_lines);
   wire ccdt_line_t frame_last = has_adj ? frame_lines
                                         : frame_lines - 11'h001;
   wire ccdt_pix_t cur_len = adj_line ? adj_len : line_len;

   // Line and frame boundaries.
   wire logic running = (state_ff != CCDT_ST_IDLE);
   wire logic eol = running && (pix_cnt_ff == cur_len - 12'h001);
   wire logic eof = eol && (line_cnt_ff == frame_last);
   wire logic start = !running && run;
   wire logic restart = eof && run;

   // Sweep ends at the given count in its last line.
   wire logic sweep_done = (state_ff == CCDT_ST_SWEEP) &&
                           (line_cnt_ff == sweep_last) &&
                           (pix_cnt_ff == sweep_end);

   // Pixel counter restarts with each line sync falling edge.
   always_comb begin
      if (!running || eol) begin
         nxt_pix = 12'h000;
      end else begin
         nxt_pix = pix_cnt_ff + 12'h001;
      end
   end

   // Line counter wraps at the frame length of the latched mode.
   always_comb begin
      if (!running || eof) begin
         nxt_line = 11'h000;
      end else if (eol) begin
         nxt_line = line_cnt_ff + 11'h001;
      end else begin
         nxt_line = line_cnt_ff;
      end
   end

   // A new mode is taken only at a frame boundary.
   assign nxt_mode = (start || restart) ? req_mode : mode_ff;

   // Frame sequencer: sweep lines, one shift line, then transfer.
   always_comb begin
      case (state_ff)
         CCDT_ST_IDLE: begin
            nxt_state = run ? start_state : CCDT_ST_IDLE;
         end
         CCDT_ST_SWEEP: begin
            if (eol && line_cnt_ff == sweep_last) begin
               nxt_state = CCDT_ST_SHIFT;
            end else begin
               nxt_state = CCDT_ST_SWEEP;
            end
         end
         CCDT_ST_SHIFT: begin
            nxt_state = eof ? (run ? start_state : CCDT_ST_IDLE)
                      : (eol ? CCDT_ST_XFER : CCDT_ST_SHIFT);
         end
         CCDT_ST_XFER: begin
            if (eof) begin
               nxt_state = run ? start_state : CCDT_ST_IDLE;
            end else begin
               nxt_state = CCDT_ST_XFER;
            end
         end
         default: begin
            nxt_state = CCDT_ST_IDLE;
         end
      endcase
   end

   // Sweep flag and frame shift flag for the coming cycle.
   always_comb begin
      if ((start || restart) && nxt_state == CCDT_ST_SWEEP) begin
         nxt_sweep = 1'b1;
      end else if (sweep_done || nxt_state != CCDT_ST_SWEEP) begin
         nxt_sweep = 1'b0;
      end else begin
         nxt_sweep = sweep_active_ff;
      end
   end
   assign nxt_shift = (nxt_state == CCDT_ST_SHIFT);

   // Sequencer registers.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= CCDT_ST_IDLE;
         mode_ff <= CCDT_FF15;
         pix_cnt_ff <= 12'h000;
         line_cnt_ff <= 11'h000;
         sweep_active_ff <= 1'b0;
         frame_shift_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mode_ff <= nxt_mode;
         pix_cnt_ff <= nxt_pix;
         line_cnt_ff <= nxt_line;
         sweep_active_ff <= nxt_sweep;
         frame_shift_ff <= nxt_shift;
      end
   end

   // Publish the positions to the gate generators.
   assign u_cif.pix = pix_cnt_ff;
   assign u_cif.line = line_cnt_ff;

   // Pulse windows; sweep rise edges and the readout end per rate, all other edges shared.
   wire logic sw = sweep_active_ff;
   wire logic in_shift = (state_ff == CCDT_ST_SHIFT);
   wire ccdt_pix_t sw_hld_rise = rate29 ? CCDT_SW_HLD_RISE_29
                                        : CCDT_SW_HLD_RISE_36;
   wire ccdt_pix_t sw_str_rise = rate29 ? CCDT_SW_STR_RISE_29
                                        : CCDT_SW_STR_RISE_36;
   wire ccdt_pix_t str_on = sw ? CCDT_SW_STR_FALL : CCDT_NT_STR_FALL;
   wire ccdt_pix_t str_off = sw ? sw_str_rise : CCDT_NT_STR_RISE;
   wire ccdt_pix_t hld_on = sw ? CCDT_SW_HLD_FALL : CCDT_NT_HLD_FALL;
   wire ccdt_pix_t hld_off = sw ? sw_hld_rise : CCDT_NT_HLD_RISE;
   wire logic gate_en = running && (sw || state_ff != CCDT_ST_SWEEP);

   // Drain from storage fall to hold rise in sweep, or in blanking.
   wire logic smear_sub = smear_test && (state_ff == CCDT_ST_XFER);
   wire logic sub_en = !in_shift && (sw || smear_sub);
   wire ccdt_pix_t sub_on = sw ? CCDT_SW_STR_FALL : CCDT_HB_SUB_ON;
   wire ccdt_pix_t sub_off = sw ? sw_hld_rise : CCDT_HB_SUB_OFF;

   // Readout is withheld while smear testing.
   wire logic rd_en = in_shift && !smear_test;
   wire ccdt_pix_t rd_off = rate29 ? CCDT_RD_OFF_29 : CCDT_RD_OFF_36;
   wire logic fsync_en = running && (line_cnt_ff == 11'h000);

   // Line sync, low for the sync width at the start of every line.
   ccdt_pulse_gen #(.IDLE_LVL(1'b1)) u_lsync (
      .clk(clk),
      .srst(srst),
      .cnt(u_cif.mon),
      .en(running),
      .on_pos(12'h000),
      .off_pos(CCDT_SYNC_W),
      .pulse_ff(line_sync_pulse_n_ff)
   );

   // Frame sync, low during the sync width of line zero.
   ccdt_pulse_gen #(.IDLE_LVL(1'b1)) u_fsync (
      .clk(clk),
      .srst(srst),
      .cnt(u_cif.mon),
      .en(fsync_en),
      .on_pos(12'h000),
      .off_pos(CCDT_SYNC_W),
      .pulse_ff(frame_sync_pulse_n_ff)
   );

   // Storage gate, idle high, low inside its window.
   ccdt_pulse_gen #(.IDLE_LVL(1'b1)) u_str (
      .clk(clk),
      .srst(srst),
      .cnt(u_cif.mon),
      .en(gate_en),
      .on_pos(str_on),
      .off_pos(str_off),
      .pulse_ff(vertical_storage_gate_ff)
   );

   // Hold gate, idle high, low inside its window.
   ccdt_pulse_gen #(.IDLE_LVL(1'b1)) u_hld (
      .clk(clk),
      .srst(srst),
      .cnt(u_cif.mon),
      .en(gate_en),
      .on_pos(hld_on),
      .off_pos(hld_off),
      .pulse_ff(vertical_hold_gate_ff)
   );

   // Substrate drain pulse, active high.
   ccdt_pulse_gen #(.IDLE_LVL(1'b0)) u_sub (
      .clk(clk),
      .srst(srst),
      .cnt(u_cif.mon),
      .en(sub_en),
      .on_pos(sub_on),
      .off_pos(sub_off),
      .pulse_ff(substrate_drain_ff)
   );

   // Readout pulse in the frame shift line, active high.
   ccdt_pulse_gen #(.IDLE_LVL(1'b0)) u_rd (
      .clk(clk),
      .srst(srst),
      .cnt(u_cif.mon),
      .en(rd_en),
      .on_pos(CCDT_RD_ON),
      .off_pos(rd_off),
      .pulse_ff(readout_pulse_ff)
   );

endmodule // ccdt_timing_gen

// >>> rtl/ccdt_pkg.sv
package ccdt_pkg;

   // Operating modes: three full-frame and two centre-window.
   typedef enum logic [2:0] {
      CCDT_FF15   = 3'h0,
      CCDT_FF12P5 = 3'h1,
      CCDT_FF22P5 = 3'h2,
      CCDT_CW30   = 3'h3,
      CCDT_CW25   = 3'h4
   } ccdt_mode_e;

   // Frame sequencer states, Gray coded along idle-sweep-shift-transfer.
   typedef enum logic [1:0] {
      CCDT_ST_IDLE  = 2'h0,
      CCDT_ST_SWEEP = 2'h1,
      CCDT_ST_SHIFT = 2'h3,
      CCDT_ST_XFER  = 2'h2
   } ccdt_state_e;

   typedef logic [11:0] ccdt_pix_t;
   typedef logic [10:0] ccdt_line_t;

   localparam int CCDT_NMODES = 5;

   // Per-mode tables, indexed by the mode code.
   // Clocks per line: 1650, 1600, 1600, 1598, 1556.
   localparam ccdt_pix_t CCDT_LINE_LEN [CCDT_NMODES] =
      '{12'h672, 12'h640, 12'h640, 12'h63e, 12'h614};
   // Fractional adjustment line length: none, none, none, 2700, 2336.
   localparam ccdt_pix_t CCDT_ADJ_LEN [CCDT_NMODES] =
      '{12'h000, 12'h000, 12'h000, 12'ha8c, 12'h920};
   // Normal lines per frame: 1456, 1450, 1001, 750, 744.
   localparam ccdt_line_t CCDT_FRAME_LINES [CCDT_NMODES] =
      '{11'h5b0, 11'h5aa, 11'h3e9, 11'h2ee, 11'h2e8};
   // Lines in the high-speed sweep: 60, 52, none, 8, 6.
   localparam ccdt_line_t CCDT_SWEEP_LINES [CCDT_NMODES] =
      '{11'h03c, 11'h034, 11'h000, 11'h008, 11'h006};
   // Sweep end position in the last sweep line: 144, 120, -, 144, 120.
   localparam ccdt_pix_t CCDT_SWEEP_END [CCDT_NMODES] =
      '{12'h090, 12'h078, 12'h000, 12'h090, 12'h078};
   // Pixel clock rate: 1 means 29.0 MHz, 0 means 36.0 MHz.
   localparam logic CCDT_RATE29 [CCDT_NMODES] =
      '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

   // Sync pulse width in clocks.
   localparam ccdt_pix_t CCDT_SYNC_W = 12'h010;

   // Sweep block positions, counted from the line sync falling edge.
   localparam ccdt_pix_t CCDT_SW_HLD_FALL = 12'h008;
   localparam ccdt_pix_t CCDT_SW_STR_FALL = 12'h014;
   localparam ccdt_pix_t CCDT_SW_HLD_RISE_36 = 12'h082;
   localparam ccdt_pix_t CCDT_SW_HLD_RISE_29 = 12'h06f;
   localparam ccdt_pix_t CCDT_SW_STR_RISE_36 = 12'h08c;
   localparam ccdt_pix_t CCDT_SW_STR_RISE_29 = 12'h078;

   // Normal transfer positions, shared by both pixel clock rates.
   localparam ccdt_pix_t CCDT_NT_HLD_FALL = 12'h028;
   localparam ccdt_pix_t CCDT_NT_STR_FALL = 12'h03c;
   localparam ccdt_pix_t CCDT_NT_HLD_RISE = 12'h064;
   localparam ccdt_pix_t CCDT_NT_STR_RISE = 12'h078;

   // Readout pulse positions in the frame shift line.
   localparam ccdt_pix_t CCDT_RD_ON = 12'h0c8;
   localparam ccdt_pix_t CCDT_RD_OFF_36 = 12'h106;
   localparam ccdt_pix_t CCDT_RD_OFF_29 = 12'h0fa;

   // Charge drain window in horizontal blanking for smear testing.
   localparam ccdt_pix_t CCDT_HB_SUB_ON = 12'h020;
   localparam ccdt_pix_t CCDT_HB_SUB_OFF = 12'h060;

endpackage

// >>> rtl/ccdt_cnt_if.sv
`timescale 1ns/10ps

// Carries the pixel and line positions from the sequencer to the gates.
interface ccdt_cnt_if;
   import ccdt_pkg::*;
   ccdt_pix_t pix;
   ccdt_line_t line;
   modport drv (output pix, output line);
   modport mon (input pix, input line);
endinterface

// >>> rtl/ccdt_pulse_gen.sv
`timescale 1ns/10ps

// Registered window pulse: active while on_pos <= pixel count < off_pos.
module ccdt_pulse_gen
   import ccdt_pkg::*;
#(
   parameter logic IDLE_LVL = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   ccdt_cnt_if.mon cnt,
   input wire logic en,
   input wire ccdt_pix_t on_pos,
   input wire ccdt_pix_t off_pos,
   output logic pulse_ff
);

   wire logic hit;
   wire logic nxt_pulse;

   // Window compare against the shared pixel count.
   assign hit = en && (cnt.pix >= on_pos) && (cnt.pix < off_pos);
   assign nxt_pulse = hit ? ~IDLE_LVL : IDLE_LVL;

   // The output level is held in a flip-flop.
   always_ff @(posedge clk) begin
      if (srst) begin
         pulse_ff <= IDLE_LVL;
      end else begin
         pulse_ff <= nxt_pulse;
      end
   end

endmodule // ccdt_pulse_gen

// >>> tb/ccdt_timing_gen_asserts.sv
`timescale 1ns/10ps

// Watches the drive pins for sync, gate and drain ordering.
module ccdt_timing_gen_asserts
   import ccdt_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic smear_test,
   input wire logic line_sync_pulse_n_ff,
   input wire logic frame_sync_pulse_n_ff,
   input wire logic vertical_storage_gate_ff,
   input wire logic vertical_hold_gate_ff,
   input wire logic substrate_drain_ff,
   input wire logic readout_pulse_ff,
   input wire logic sweep_active_ff,
   input wire logic frame_shift_ff,
   input wire ccdt_pix_t pix_cnt_ff,
   input wire ccdt_line_t line_cnt_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   // Line sync placement and width, frame sync placement, and pixel count steps.
   sync_width_a: assert property (
      $fell(line_sync_pulse_n_ff) |-> ##16 $rose(line_sync_pulse_n_ff))
      else $error("line sync width wrong");
   sync_phase_a: assert property (
      $fell(line_sync_pulse_n_ff) |-> $past(pix_cnt_ff) == 12'h000)
      else $error("line sync off pixel zero");
   frame_sync_a: assert property (
      $fell(frame_sync_pulse_n_ff) == ($fell(line_sync_pulse_n_ff)
      && line_cnt_ff == 11'h000)) else $error("frame sync misplaced");
   pix_step_a: assert property (
      pix_cnt_ff != 12'h000 |-> pix_cnt_ff == $past(pix_cnt_ff) + 12'h001)
      else $error("pixel count skipped");
   // Drain pulse tied to the sweep gates and kept out of frame shift; readout and transfer storage fall placement.
   drain_rise_a: assert property (
      $rose(substrate_drain_ff) && sweep_active_ff
      |-> $fell(vertical_storage_gate_ff)) else $error("drain rise late");
   drain_fall_a: assert property (
      $fell(substrate_drain_ff) && sweep_active_ff
      |-> $rose(vertical_hold_gate_ff)) else $error("drain fall late");
   no_drain_shift_a: assert property (
      frame_shift_ff |-> !substrate_drain_ff) else $error("drain in shift");
   readout_gate_a: assert property (
      readout_pulse_ff |-> frame_shift_ff && !smear_test)
      else $error("stray readout pulse");
   xfer_store_a: assert property (
      $fell(vertical_storage_gate_ff) && !sweep_active_ff && !frame_shift_ff
      |-> $past(pix_cnt_ff) == 12'h03c) else $error("storage fall moved");
endmodule // ccdt_timing_gen_asserts

bind ccdt_timing_gen ccdt_timing_gen_asserts ccdt_timing_gen_asserts_i (
   .clk(clk), .srst(srst), .smear_test(smear_test),
   .line_sync_pulse_n_ff(line_sync_pulse_n_ff),
   .frame_sync_pulse_n_ff(frame_sync_pulse_n_ff),
   .vertical_storage_gate_ff(vertical_storage_gate_ff),
   .vertical_hold_gate_ff(vertical_hold_gate_ff),
   .substrate_drain_ff(substrate_drain_ff),
   .readout_pulse_ff(readout_pulse_ff), .sweep_active_ff(sweep_active_ff),
   .frame_shift_ff(frame_shift_ff), .pix_cnt_ff(pix_cnt_ff),
   .line_cnt_ff(line_cnt_ff)
);

// >>> tb/ccdt_sensor_model.sv
`timescale 1ns/10ps

// Sensor stand-in: a drain pulse during frame shift would wipe the rows
// being moved, so it is latched as a fault.
module ccdt_sensor_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic drain,
   input wire logic shift,
   output logic drain_fault_ff
);
   // Fault flag clears only on reset.
   always_ff @(posedge clk) begin
      if (srst) begin
         drain_fault_ff <= 1'b0;
      end else begin
         drain_fault_ff <= drain_fault_ff | (drain & shift);
      end
   end
endmodule // ccdt_sensor_model

// >>> tb/ccdt_timing_gen_bench.sv
`timescale 1ns/10ps

// Runs each mode from reset and checks line lengths and pulse widths.
module ccdt_timing_gen_bench;
   import ccdt_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic run = 1'b0;
   logic [2:0] mode_sel = 3'h0;
   logic smear_test = 1'b0;
   logic ls_n, fs_n, stor, hold, drain, rd, sw, shift, fault;
   ccdt_pix_t pix;
   ccdt_line_t line;
   int fails = 0;
   int n_checks = 0;
   int c_line, c_drain, c_rd;
   logic seen, sw_q, ls_q;
   logic [22:0] pos_q;
   logic [31:0] lfsr = 32'h4cbc;
   logic [31:0] q_line[$], q_drain[$], q_rd[$], q_end[$];

   ccdt_timing_gen ccdt_timing_gen_i (
      .clk(clk), .srst(srst), .run(run), .mode_sel(mode_sel),
      .smear_test(smear_test), .line_sync_pulse_n_ff(ls_n),
      .frame_sync_pulse_n_ff(fs_n), .vertical_storage_gate_ff(stor),
      .vertical_hold_gate_ff(hold), .substrate_drain_ff(drain),
      .readout_pulse_ff(rd), .sweep_active_ff(sw), .frame_shift_ff(shift),
      .pix_cnt_ff(pix), .line_cnt_ff(line)
   );
   ccdt_sensor_model ccdt_sensor_model_i (
      .clk(clk), .srst(srst), .drain(drain), .shift(shift),
      .drain_fault_ff(fault)
   );

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   // Next state of the stimulus shift register.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Oldest note of a queue; an empty queue yields a value no result has.
   function automatic logic [31:0] take(ref logic [31:0] q[$]);
      return (q.size() > 0) ? q.pop_front() : 32'hffffffff;
   endfunction

   // Common compare: counts the check and reports a mismatch.
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Length of one line, in clocks between two line sync falls.
   task automatic chk_line(input int got, input logic [31:0] exp);
      chk_val(got, exp);
   endtask

   // Width of one drain or readout pulse, in clocks.
   task automatic chk_width(input int got, input logic [31:0] exp);
      chk_val(got, exp);
   endtask

   // Line and pixel position at which the sweep stopped.
   task automatic chk_end(input logic [22:0] got, input logic [31:0] exp);
      chk_val({9'h000, got}, exp);
   endtask

   task automatic close_out();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Resets, notes the expected results, then runs for the given number of lines plus 300 clocks.
   task automatic run_mode(input logic [2:0] m, input logic sm,
         input int lines, input int len, input int sl, input int se,
         input int nd, input int wd, input int wr);
      @(negedge clk);
      srst = 1'b1;
      run = 1'b0;
      mode_sel = m;
      smear_test = sm;
      repeat (16) @(negedge clk);
      chk_val({ls_n, fs_n, stor, hold, drain, rd, sw, shift}, 8'hf0);
      srst = 1'b0;
      lfsr = lfsr_next(lfsr);
      repeat (lfsr[2:0]) @(negedge clk);
      for (int i = 0; i < lines; i++) q_line.push_back(len);
      for (int i = 0; i < nd; i++) q_drain.push_back(wd);
      if (wr > 0) q_rd.push_back(wr);
      if (sl > 0) q_end.push_back({11'(sl - 1), 12'(se)});
      run = 1'b1;
      repeat (lines * len + 300) @(negedge clk);
   endtask

   // Measures each result and compares it with the oldest note.
   always @(negedge clk) begin
      if (srst) begin
         seen = 1'b0;
         ls_q = 1'b1;
         sw_q = 1'b0;
         c_line = 0;
         c_drain = 0;
         c_rd = 0;
      end else begin
         c_line++;
         if (ls_q && !ls_n) begin
            if (seen) chk_line(c_line, take(q_line));
            // Frame sync falls with the first line sync of a frame only.
            chk_val({31'h0, fs_n}, {31'h0, seen});
            seen = 1'b1;
            c_line = 0;
         end
         if (drain) c_drain++;
         else if (c_drain > 0) chk_width(c_drain, take(q_drain));
         if (!drain) c_drain = 0;
         if (rd) c_rd++;
         else if (c_rd > 0) chk_width(c_rd, take(q_rd));
         if (!rd) c_rd = 0;
         if (sw_q && !sw) chk_end(pos_q, take(q_end));
         ls_q = ls_n;
         sw_q = sw;
         pos_q = {line, pix};
      end
   end

   // Main sequence; the unknown mode codes 6 and 7 stand for mode 0.
   initial begin
      lfsr = lfsr_next(lfsr);
      run_mode(3'h7 - {2'h0, lfsr[0]}, 1'b0, 2, 1650, 0, 0, 3, 110, 0);
      run_mode(3'h1, 1'b0, 2, 1600, 0, 0, 3, 91, 0);
      run_mode(3'h2, 1'b0, 1, 1600, 0, 0, 0, 0, 62);
      run_mode(3'h2, 1'b1, 1, 1600, 0, 0, 1, 64, 0);
      run_mode(3'h3, 1'b0, 8, 1598, 8, 144, 8, 110, 62);
      run_mode(3'h4, 1'b0, 6, 1556, 6, 120, 6, 91, 50);
      chk_val(q_line.size() + q_drain.size(), 0);
      chk_val(q_rd.size() + q_end.size(), 0);
      chk_val({31'h0, fault}, 0);
      close_out();
   end

   // Cuts a hang short; the sequence needs about 34k cycles.
   initial begin
      #600000;
      fails++;
      close_out();
   end
endmodule // ccdt_timing_gen_bench
